/* logic/idcw_top.sv */
// i2c slave write path loading dac channel registers
`timescale 1ns/10ps
//
// Contract
// RULE_01 - master opens each write with START and address byte, read/write bit zero.
// RULE_02 - device acknowledges a matching address byte by pulling sda low.
// RULE_03 - pointer byte follows address, selects channel, and is acknowledged.
// RULE_04 - two data bytes follow pointer; single update then ends with STOP.
// RULE_05 - one full four-byte transaction updates exactly one channel.
// RULE_06 - address accepted once; later updates are pointer plus two data bytes.
// RULE_07 - two register-select bits in data choose the written register.
// RULE_08 - without STOP, next byte is a new pointer, then two data bytes.
// RULE_09 - STOP anywhere ends the sequence and waits for a new START.
// RULE_10 - address is fixed upper five bits plus two address-select pin levels.
// RULE_11 - acknowledge held low through ninth scl clock of each accepted byte.
// RULE_12 - pointer byte is two zero bits then six-bit channel address.
// RULE_13 - first data byte: select bits and upper data; second: lower data.
module idcw_top
  import idcw_pkg::*;
#(
  parameter int CHAN_BITS = IDCW_CHAN_BITS,
  parameter int WORD_BITS = IDCW_WORD_BITS
)
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // i2c pins, sda open drain
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // address-select straps
  input  wire logic                 slave_addr_pin_high,
  input  wire logic                 slave_addr_pin_low,
  // channel write strobe and data
  output logic                      wr_valid,
  output logic [CHAN_BITS-1:0]      channel_address,
  output logic                      register_select_high,
  output logic                      register_select_low,
  output logic [WORD_BITS-1:0]      dac_input_word
);
  // ---------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic [1:0] strap_meta_q;
  logic [1:0] strap_q;

  idcw_sync u_sync
  (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .sda_s     (sda_s),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // straps pass two flops too
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_meta_q <= 2'h0;
      strap_q      <= 2'h0;
    end
    else
    begin
      strap_meta_q <= {slave_addr_pin_high, slave_addr_pin_low};
      strap_q      <= strap_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // byte receiver
  // ---------------------------------------------------------------
  idcw_state_t      state_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       hi_byte_q;
  logic [CHAN_BITS-1:0] chan_q;
  logic             ack_q;
  logic [7:0]       byte_now;
  logic             byte_done;

  // byte with the eighth bit sampled on this rising edge
  assign byte_now  = {shift_q[6:0], sda_s};
  assign byte_done = scl_rise & (bit_cnt_q == 4'h7);

  // address match: fixed part, strap pins, write direction
  function automatic logic addr_match(input logic [7:0] b, input logic [1:0] pins);
    addr_match = (b[7:3] == IDCW_ADDR_FIXED) && (b[2:1] == pins) && !b[0]; // RULE_10
  endfunction

  // bit counter: 0..7 data, 8 ack slot low, 9 ack clock high
  // the ninth rise must not count as a data bit of the next byte
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      bit_cnt_q <= IDCW_BIT_CNT_RST;
    else if (start_det || stop_det)
      bit_cnt_q <= IDCW_BIT_CNT_RST;
    else if (scl_fall && bit_cnt_q == IDCW_ACK_END)
      bit_cnt_q <= IDCW_BIT_CNT_RST;
    else if (scl_rise && bit_cnt_q != IDCW_ACK_END)
      bit_cnt_q <= bit_cnt_q + 4'h1;
  end

  // serial shift, msb first
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      shift_q <= 8'h00;
    else if (scl_rise && bit_cnt_q < IDCW_ACK_BIT)
      shift_q <= byte_now;
  end

  // phase sequencing
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= IDCW_IDLE;
    else if (stop_det)
      state_q <= IDCW_IDLE; // RULE_09
    else if (start_det)
      state_q <= IDCW_ADDR; // RULE_01
    else if (byte_done)
    begin
      unique case (state_q)
        IDCW_IDLE: state_q <= IDCW_IDLE;
        IDCW_ADDR: state_q <= addr_match(byte_now, strap_q) ? IDCW_PTR : IDCW_IGN; // RULE_02
        IDCW_PTR:  state_q <= (byte_now[7:6] == IDCW_PTR_LEAD) ? IDCW_DHI : IDCW_IGN; // RULE_03
        IDCW_DHI:  state_q <= IDCW_DLO; // RULE_04
        IDCW_DLO:  state_q <= IDCW_PTR; // RULE_08
        IDCW_IGN:  state_q <= IDCW_IGN;
        default:   state_q <= IDCW_IGN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // acknowledge drive
  // ---------------------------------------------------------------
  // armed when an accepted byte completes, cleared as scl falls after the eighth bit
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else if (start_det || stop_det)
      ack_q <= 1'b0;
    else if (byte_done)
    begin
      unique case (state_q)
        IDCW_ADDR: ack_q <= addr_match(byte_now, strap_q); // RULE_02
        IDCW_PTR:  ack_q <= (byte_now[7:6] == IDCW_PTR_LEAD); // RULE_03
        IDCW_DHI:  ack_q <= 1'b1;
        IDCW_DLO:  ack_q <= 1'b1;
        default:   ack_q <= 1'b0;
      endcase
    end
    else if (scl_fall && bit_cnt_q == IDCW_ACK_BIT)
      ack_q <= 1'b0; // RULE_11
  end

  // drive low only in the acknowledge slot, after scl falls past bit 8
  logic ack_drive_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_drive_q <= 1'b0;
    else if (start_det || stop_det)
      ack_drive_q <= 1'b0;
    else if (scl_fall && bit_cnt_q == IDCW_ACK_BIT)
      ack_drive_q <= ack_q; // RULE_11
    else if (scl_fall && bit_cnt_q == IDCW_ACK_END)
      ack_drive_q <= 1'b0; // RULE_11
  end

  assign sda_o  = 1'b0;
  assign sda_oe = ack_drive_q;

  // ---------------------------------------------------------------
  // channel and data capture
  // ---------------------------------------------------------------
  // pointer gives channel, first data byte held until second
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chan_q    <= IDCW_CHAN_RST;
      hi_byte_q <= 8'h00;
    end
    else if (byte_done && state_q == IDCW_PTR)
      chan_q <= byte_now[CHAN_BITS-1:0]; // RULE_12
    else if (byte_done && state_q == IDCW_DHI)
      hi_byte_q <= byte_now; // RULE_13
  end

  // one write strobe per completed pointer/data group
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_valid             <= 1'b0;
      channel_address      <= IDCW_CHAN_RST;
      register_select_high <= 1'b0;
      register_select_low  <= 1'b0;
      dac_input_word       <= IDCW_WORD_RST;
    end
    else
    begin
      wr_valid <= byte_done && (state_q == IDCW_DLO) && !stop_det && !start_det; // RULE_05 RULE_06
      if (byte_done && state_q == IDCW_DLO && !stop_det && !start_det)
      begin
        channel_address      <= chan_q;
        register_select_high <= hi_byte_q[7]; // RULE_07
        register_select_low  <= hi_byte_q[6]; // RULE_07
        dac_input_word       <= {hi_byte_q[IDCW_HI_DATA_BITS-1:0], byte_now}; // RULE_13
      end
    end
  end
endmodule

/* logic/idcw_pkg.sv */
// constants and types of the i2c dac channel write path
package idcw_pkg;
  // fixed upper five bits of the 7-bit slave address
  localparam logic [4:0] IDCW_ADDR_FIXED   = 5'h15;
  // byte geometry
  localparam int         IDCW_BYTE_BITS    = 8;
  localparam logic [3:0] IDCW_ACK_BIT      = 4'h8;
  // count while the ninth (acknowledge) clock is high
  localparam logic [3:0] IDCW_ACK_END      = 4'h9;
  localparam logic [3:0] IDCW_BIT_CNT_RST  = 4'h0;
  // pointer byte layout
  localparam int         IDCW_CHAN_BITS    = 6;
  localparam logic [1:0] IDCW_PTR_LEAD     = 2'h0;
  // dac word layout
  localparam int         IDCW_WORD_BITS    = 14;
  localparam int         IDCW_HI_DATA_BITS = 6;
  localparam logic [13:0] IDCW_WORD_RST    = 14'h0000;
  localparam logic [5:0]  IDCW_CHAN_RST    = 6'h00;

  // receiver phases
  typedef enum logic [2:0]
  {
    IDCW_IDLE  = 3'b000,
    IDCW_ADDR  = 3'b001,
    IDCW_PTR   = 3'b010,
    IDCW_DHI   = 3'b011,
    IDCW_DLO   = 3'b100,
    IDCW_IGN   = 3'b101
  } idcw_state_t;
endpackage

/* logic/idcw_sync.sv */
// two-flop synchroniser with edge and start/stop detection for scl and sda
`timescale 1ns/10ps
module idcw_sync
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // conditioned events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      sda_s,
  output logic      start_det,
  output logic      stop_det
);
  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;
  logic       scl_old_q;
  logic       sda_old_q;

  // double registering of the pins, idle high
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_old_q  <= 1'b1;
      sda_old_q  <= 1'b1;
    end
    else
    begin
      scl_meta_q <= {scl_meta_q[0], scl_i};
      sda_meta_q <= {sda_meta_q[0], sda_i};
      scl_old_q  <= scl_meta_q[1];
      sda_old_q  <= sda_meta_q[1];
    end
  end

  // edges and bus conditions from synchronised levels only
  assign sda_s     = sda_meta_q[1];
  assign scl_rise  = scl_meta_q[1] & ~scl_old_q;
  assign scl_fall  = ~scl_meta_q[1] & scl_old_q;
  assign start_det = scl_meta_q[1] & scl_old_q & sda_old_q & ~sda_meta_q[1];
  assign stop_det  = scl_meta_q[1] & scl_old_q & ~sda_old_q & sda_meta_q[1];
endmodule

/* test/idcw_checker.sv */
// port assertions for the i2c dac channel write path
`timescale 1ns/10ps
module idcw_checker
  import idcw_pkg::*;
#(
  parameter int CHAN_BITS = IDCW_CHAN_BITS,
  parameter int WORD_BITS = IDCW_WORD_BITS
)
(
  // clock, reset and bus pins
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  input wire logic                 slave_addr_pin_high,
  input wire logic                 slave_addr_pin_low,
  // channel write side
  input wire logic                 wr_valid,
  input wire logic [CHAN_BITS-1:0] channel_address,
  input wire logic                 register_select_high,
  input wire logic                 register_select_low,
  input wire logic [WORD_BITS-1:0] dac_input_word
);
  // all checks on the system clock
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_sda_drive_low: assert property (sda_o == 1'b0)
    else $error("sda drive not low");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("ack moved while scl high");
  a_ack_holds: assert property (sda_oe && $rose(scl_i) |=> sda_oe [*3])
    else $error("ack dropped in ninth clock");
  a_ack_ends: assert property ($rose(sda_oe) |-> ##[1:60] !sda_oe)
    else $error("ack held too long");
  a_write_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write strobe too long");
  a_write_no_ack: assert property (wr_valid |-> !sda_oe)
    else $error("write strobe during ack");
  a_write_then_ack: assert property (wr_valid |-> ##[1:30] sda_oe)
    else $error("data byte not acknowledged");
  a_word_at_write: assert property ($changed(dac_input_word) |-> wr_valid)
    else $error("word changed without write");
endmodule

/* test/idcw_i2c_master.sv */
// i2c bus master model driving scl and sda
`timescale 1ns/10ps
module idcw_i2c_master #(
  parameter int H = 10
)
(
  // clock and bus
  input  wire logic clk_sys,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda
);
  // bus released high at time zero
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // data changes only while scl is low, msb first
  task automatic put_bit(input logic v);
    tick(2);
    sda <= v;
    tick(H);
    scl <= 1'b1;
    tick(H);
    scl <= 1'b0;
  endtask
  // eight bits then release sda for the ack clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    tick(2);
    sda <= 1'b1;
    tick(H);
    scl <= 1'b1;
    tick(H);
    ack = ~sda_w;
    scl <= 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    tick(2);
    sda <= 1'b1;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda <= 1'b0;
    tick(H);
    scl <= 1'b0;
  endtask
  // stop ends the transaction
  task automatic stop();
    tick(2);
    sda <= 1'b0;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda <= 1'b1;
    tick(H);
  endtask
endmodule

/* test/idcw_top_tb.sv */
// testbench for the i2c dac channel write path
`timescale 1ns/10ps
module idcw_top_tb;
  import idcw_pkg::*;
  logic        clk_sys, sys_rst, pin_h, pin_l, ack, sda_o, sda_oe;
  logic        scl, sda_m, sda_w, wr_valid, sel_h, sel_l;
  logic [5:0]  chan;
  logic [13:0] word;
  logic [21:0] last;
  int          miscompares = 0, samples_checked = 0, writes = 0;

  // open drain wire with pull-up
  assign sda_w = sda_m & ~sda_oe;
  idcw_top idcw_top_inst (.clk_sys, .sys_rst, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe,
    .slave_addr_pin_high(pin_h), .slave_addr_pin_low(pin_l), .wr_valid,
    .channel_address(chan), .register_select_high(sel_h), .register_select_low(sel_l),
    .dac_input_word(word));
  idcw_i2c_master idcw_i2c_master_inst (.clk_sys, .sda_w, .scl, .sda(sda_m));

  // clock and write capture
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (wr_valid === 1'b1)
    begin
      writes++;
      last = {chan, sel_h, sel_l, word};
    end

  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] addr(input logic h, l, rw);
    return {IDCW_ADDR_FIXED, h, l, rw};
  endfunction
  task automatic send(input logic [7:0] b, input logic exp);
    idcw_i2c_master_inst.put_byte(b, ack);
    chk(ack, exp);
  endtask
  // pointer and two data bytes, one write expected
  task automatic grp(input logic [5:0] c, input logic [1:0] s, input logic [13:0] d);
    int n;
    n = writes;
    send({IDCW_PTR_LEAD, c}, 1'b1);
    send({s, d[13:8]}, 1'b1);
    send(d[7:0], 1'b1);
    chk(writes, n + 1);
    chk(last, {c, s, d});
  endtask
  task automatic t_single();
    idcw_i2c_master_inst.start();
    send(addr(1'b1, 1'b0, 1'b0), 1'b1);
    grp(6'h05, 2'h1, 14'h2ac3);
    idcw_i2c_master_inst.stop();
  endtask
  task automatic t_multi();
    idcw_i2c_master_inst.start();
    send(addr(1'b1, 1'b0, 1'b0), 1'b1);
    for (int k = 0; k < 4; k++)
      grp(6'(39 - k), 2'(k), 14'h3fff ^ 14'(k * 321));
    idcw_i2c_master_inst.stop();
  endtask
  // wrong strap address and read request are refused
  task automatic t_refuse();
    int n;
    n = writes;
    idcw_i2c_master_inst.start();
    send(addr(1'b0, 1'b1, 1'b0), 1'b0);
    idcw_i2c_master_inst.start();
    send(addr(1'b1, 1'b0, 1'b1), 1'b0);
    idcw_i2c_master_inst.stop();
    chk(writes, n);
  endtask
  // stop mid group, then the first byte must be an address again
  task automatic t_abort();
    int n;
    n = writes;
    idcw_i2c_master_inst.start();
    send(addr(1'b1, 1'b0, 1'b0), 1'b1);
    send(8'h03, 1'b1);
    send(8'h55, 1'b1);
    idcw_i2c_master_inst.stop();
    idcw_i2c_master_inst.start();
    send(8'h03, 1'b0);
    chk(writes, n);
    idcw_i2c_master_inst.start();
    send(addr(1'b1, 1'b0, 1'b0), 1'b1);
    grp(6'h3f, 2'h3, 14'h1555);
    idcw_i2c_master_inst.stop();
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    pin_h = 1'b1;
    pin_l = 1'b0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    t_single();
    t_multi();
    t_refuse();
    t_abort();
    final_report();
  end
  // watchdog
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
endmodule

bind idcw_top idcw_checker #(.CHAN_BITS(CHAN_BITS), .WORD_BITS(WORD_BITS)) idcw_checker_inst
  (.clk_sys, .sys_rst, .scl_i, .sda_i, .sda_o, .sda_oe, .slave_addr_pin_high,
   .slave_addr_pin_low, .wr_valid, .channel_address, .register_select_high,
   .register_select_low, .dac_input_word);
